/* File: io_space_regs.svh */
`ifndef IO_SPACE_REGS_SVH
`define IO_SPACE_REGS_SVH
// Summary of operation
// - Registers 0x00 to 0x1F accept single-bit set and clear from the core.
// - Core may test one bit of a low-range register and skip on set or clear.
// - Status flags clear on a written one; a written zero leaves them unchanged.
// - Bit set or clear touches only the addressed bit; other flags are kept.
// - Bit operations work only at 0x00 to 0x1F; I/O addresses 0x20 to 0x3F hold no registers and refuse writes.

`define IO_NREGS 32
`define IO_BITOP_LAST 8'h1F
`define IO_SPACE_LAST 8'h3F
`define IO_DATA_OFFSET 9'h020
`define IO_EXT_FIRST 9'h060
`define IO_RST_VAL 8'h00

`define ADC_CONTROL_B 5'h04
`define ADC_CONTROL_A 5'h05
`define ADC_RESULT_LOW 5'h06
`define ADC_RESULT_HIGH 5'h07
`define ADC_REFERENCE_GAIN_SELECT 5'h08
`define ADC_CHANNEL_SELECT 5'h09
`define COMPARATOR0_CONTROL_A 5'h0A
`define COMPARATOR0_CONTROL_B 5'h0B
`define COMPARATOR1_CONTROL_A 5'h0C
`define COMPARATOR1_CONTROL_B 5'h0D
`define TIMER1_FLAGS 5'h0E
`define TIMER1_IRQ_MASK 5'h0F
`define TIMER2_FLAGS 5'h10
`define TIMER2_IRQ_MASK 5'h11
`define PIN_CHANGE_MASK_LOW 5'h12
`define SCRATCH_REGISTER_0 5'h13
`define SCRATCH_REGISTER_1 5'h14
`define SCRATCH_REGISTER_2 5'h15
`define PORT_B_INPUT_LEVELS 5'h16
`define PORT_B_OUTPUT 5'h18
`define PORT_A_INPUT_LEVELS 5'h19
`define PORT_A_DIRECTION 5'h1A
`define PORT_A_OUTPUT 5'h1B
`define EEPROM_CONTROL 5'h1C
`define EEPROM_DATA 5'h1D
`define EEPROM_ADDRESS_LOW 5'h1E
`define EEPROM_ADDRESS_HIGH 5'h1F

`define MASK_ADC_CONTROL_B 8'h0F
`define MASK_ADC_CONTROL_A 8'hEF
`define MASK_ADC_REF_GAIN 8'hE3
`define MASK_ADC_CHANNEL 8'h3F
`define MASK_CMP_CONTROL_A 8'hCF
`define MASK_CMP0_CONTROL_B 8'hDF
`define MASK_CMP1_CONTROL_B 8'hD4
`define MASK_TIMER_FLAGS 8'h27
`define MASK_PORT_B 8'h0F
`define MASK_EEPROM_CONTROL 8'h3F
`define MASK_FULL 8'hFF
`define MASK_NONE 8'h00
`define FLAG_BIT_ADC_DONE 4
`define FLAG_BIT_CMP_EVENT 4
`define BIT_CMP_LEVEL 5
`endif

/* File: io_space_pkg.sv */
package io_space_pkg;
   typedef enum logic [2:0] {
      read_byte_op = 3'h0,
      write_byte_op = 3'h1,
      set_register_bit_op = 3'h2,
      clear_register_bit_op = 3'h3,
      skip_if_register_bit_set = 3'h4,
      skip_if_register_bit_clear = 3'h5
   } access_kind_e;
   typedef logic [7:0] byte_t;
endpackage

/* File: io_pin_sync.sv */
module io_pin_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // Two flops per bit, first stage read only by the second
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
         meta_d[i] = async_i[i];
         sync_d[i] = meta_q[i];
      end
      always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            meta_q[i] <= 1'b0;
            sync_q[i] <= 1'b0;
         end else begin
            meta_q[i] <= meta_d[i];
            sync_q[i] <= sync_d[i];
         end
      end
   end

   assign sync_o = sync_q;
endmodule

/* File: io_register_space_bit_access.sv */
`include "io_space_regs.svh"

module io_register_space_bit_access (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Core access port
   input wire logic acc_valid_i,
   input wire io_space_pkg::access_kind_e acc_kind_i,
   input wire logic acc_data_space_i,
   input wire logic [8:0] acc_addr_i,
   input wire logic [2:0] acc_bit_i,
   input wire logic [7:0] acc_wdata_i,
   output logic acc_ack_o,
   output logic [7:0] acc_rdata_o,
   output logic acc_skip_o,
   output logic acc_err_o,
   // Peripheral side
   input wire logic [7:0] timer1_event_i,
   input wire logic [7:0] timer2_event_i,
   input wire logic adc_done_i,
   input wire logic [15:0] adc_result_i,
   input wire logic cmp0_event_i,
   input wire logic cmp1_event_i,
   input wire logic cmp0_level_i,
   input wire logic cmp1_level_i,
   input wire logic [7:0] port_a_pin_i,
   input wire logic [3:0] port_b_pin_i,
   output logic [7:0] port_a_out_o,
   output logic [7:0] port_a_dir_o,
   output logic [3:0] port_b_out_o,
   output logic [255:0] reg_image_o
);
   logic [`IO_NREGS-1:0][7:0] reg_q;
   logic [`IO_NREGS-1:0][7:0] reg_d;
   logic [`IO_NREGS-1:0][7:0] hw_set;
   logic ack_q;
   logic ack_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic skip_q;
   logic skip_d;
   logic err_q;
   logic err_d;
   logic [7:0] pin_a;
   logic [3:0] pin_b;
   logic [8:0] io_addr;
   logic io_hit;
   logic [4:0] idx;
   logic mapped;
   logic [7:0] rd_val;
   logic is_bitop;
   logic is_write;
   logic in_bit_range;
   logic bad_write;
   logic bad_bitop;
   logic bit_seen;
   logic [7:0] onehot;
   logic [7:0] next_byte [`IO_NREGS];

   io_pin_sync #(.WIDTH(8)) u_sync_a (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .async_i(port_a_pin_i),
      .sync_o(pin_a)
   );

   io_pin_sync #(.WIDTH(4)) u_sync_b (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .async_i(port_b_pin_i),
      .sync_o(pin_b)
   );

   // Writable bits per register; zero for reserved and read-only
   function automatic logic [7:0] rw_mask(input logic [4:0] a);
      logic [7:0] m;
      m = `MASK_NONE;
      case (a)
         `ADC_CONTROL_B: m = `MASK_ADC_CONTROL_B;
         `ADC_CONTROL_A: m = `MASK_ADC_CONTROL_A;
         `ADC_REFERENCE_GAIN_SELECT: m = `MASK_ADC_REF_GAIN;
         `ADC_CHANNEL_SELECT: m = `MASK_ADC_CHANNEL;
         `COMPARATOR0_CONTROL_A: m = `MASK_CMP_CONTROL_A;
         `COMPARATOR0_CONTROL_B: m = `MASK_CMP0_CONTROL_B;
         `COMPARATOR1_CONTROL_A: m = `MASK_CMP_CONTROL_A;
         `COMPARATOR1_CONTROL_B: m = `MASK_CMP1_CONTROL_B;
         `TIMER1_IRQ_MASK: m = `MASK_TIMER_FLAGS;
         `TIMER2_IRQ_MASK: m = `MASK_TIMER_FLAGS;
         `PIN_CHANGE_MASK_LOW: m = `MASK_FULL;
         `SCRATCH_REGISTER_0: m = `MASK_FULL;
         `SCRATCH_REGISTER_1: m = `MASK_FULL;
         `SCRATCH_REGISTER_2: m = `MASK_FULL;
         `PORT_B_OUTPUT: m = `MASK_PORT_B;
         `PORT_A_DIRECTION: m = `MASK_FULL;
         `PORT_A_OUTPUT: m = `MASK_FULL;
         `EEPROM_CONTROL: m = `MASK_EEPROM_CONTROL;
         `EEPROM_DATA: m = `MASK_FULL;
         `EEPROM_ADDRESS_LOW: m = `MASK_FULL;
         `EEPROM_ADDRESS_HIGH: m = `MASK_FULL;
         default: m = `MASK_NONE;
      endcase
      return m;
   endfunction

   // Flags that clear on a written one
   function automatic logic [7:0] w1c_mask(input logic [4:0] a);
      logic [7:0] m;
      m = `MASK_NONE;
      case (a)
         `ADC_CONTROL_A: m = 8'h10;
         `COMPARATOR0_CONTROL_A: m = 8'h10;
         `COMPARATOR1_CONTROL_A: m = 8'h10;
         `TIMER1_FLAGS: m = `MASK_TIMER_FLAGS;
         `TIMER2_FLAGS: m = `MASK_TIMER_FLAGS;
         default: m = `MASK_NONE;
      endcase
      return m;
   endfunction

   // Registers that exist in the low range
   function automatic logic is_mapped(input logic [4:0] a);
      logic r;
      r = 1'b1;
      case (a)
         5'h00, 5'h01, 5'h02, 5'h03, 5'h17: r = 1'b0;
         default: r = 1'b1;
      endcase
      return r;
   endfunction

   // Address translation between data and I/O spaces
   always_comb begin
      io_addr = acc_addr_i;
      if (acc_data_space_i) begin
         io_addr = acc_addr_i - `IO_DATA_OFFSET;
      end
      io_hit = 1'b0;
      if (acc_data_space_i) begin
         io_hit = (acc_addr_i >= `IO_DATA_OFFSET) && (acc_addr_i < `IO_EXT_FIRST);
      end else begin
         io_hit = (acc_addr_i <= {1'b0, `IO_SPACE_LAST});
      end
      idx = io_addr[4:0];
      mapped = io_hit && (io_addr[8:5] == 4'h0) && is_mapped(idx);
      is_bitop = 1'b0;
      is_write = 1'b0;
      case (acc_kind_i)
         io_space_pkg::write_byte_op: begin
            is_write = 1'b1;
         end
         io_space_pkg::set_register_bit_op, io_space_pkg::clear_register_bit_op: begin
            is_bitop = 1'b1;
            is_write = 1'b1;
         end
         io_space_pkg::skip_if_register_bit_set,
         io_space_pkg::skip_if_register_bit_clear: begin
            is_bitop = 1'b1;
         end
         default: begin
            is_bitop = 1'b0;
         end
      endcase
   end

   // Refusal decode; bit ops only on the I/O path
   always_comb begin
      onehot = 8'h01 << acc_bit_i;
      in_bit_range = !acc_data_space_i && (io_addr <= {1'b0, `IO_BITOP_LAST});
      bad_write = !mapped && is_write;
      bad_bitop = is_bitop && !in_bit_range;
      bit_seen = rd_val[acc_bit_i];
   end

   // Read view, live inputs for read-only fields, port pins through the two-flop synchronizer
   always_comb begin
      rd_val = reg_q[idx];
      case (idx)
         `ADC_RESULT_LOW: rd_val = adc_result_i[7:0];
         `ADC_RESULT_HIGH: rd_val = adc_result_i[15:8];
         `PORT_B_INPUT_LEVELS: rd_val = {4'h0, pin_b};
         `PORT_A_INPUT_LEVELS: rd_val = pin_a;
         `COMPARATOR0_CONTROL_A: begin
            rd_val = reg_q[idx];
            rd_val[`BIT_CMP_LEVEL] = cmp0_level_i;
         end
         `COMPARATOR1_CONTROL_A: begin
            rd_val = reg_q[idx];
            rd_val[`BIT_CMP_LEVEL] = cmp1_level_i;
         end
         default: rd_val = reg_q[idx];
      endcase
      if (!mapped) begin
         rd_val = 8'h00;
      end
   end

   // Hardware flag events
   always_comb begin
      hw_set = '0;
      hw_set[`TIMER1_FLAGS] = timer1_event_i & `MASK_TIMER_FLAGS;
      hw_set[`TIMER2_FLAGS] = timer2_event_i & `MASK_TIMER_FLAGS;
      hw_set[`ADC_CONTROL_A][`FLAG_BIT_ADC_DONE] = adc_done_i;
      hw_set[`COMPARATOR0_CONTROL_A][`FLAG_BIT_CMP_EVENT] = cmp0_event_i;
      hw_set[`COMPARATOR1_CONTROL_A][`FLAG_BIT_CMP_EVENT] = cmp1_event_i;
   end

   // Register next state, one entry per loop pass
   for (genvar g = 0; g < `IO_NREGS; g++) begin : g_entry
      logic [7:0] rw;
      logic [7:0] wc;
      logic [7:0] clr;
      logic [7:0] upd;
      logic hit;

      always_comb begin
         rw = rw_mask(5'(g));
         wc = w1c_mask(5'(g));
         upd = reg_q[g];
         clr = `MASK_NONE;
         hit = acc_valid_i && mapped && (idx == 5'(g));
         if (hit) begin
            case (acc_kind_i)
               io_space_pkg::write_byte_op: begin
                  upd = (reg_q[g] & ~rw) | (acc_wdata_i & rw);
                  clr = acc_wdata_i & wc;
               end
               io_space_pkg::set_register_bit_op: begin
                  if (in_bit_range) begin
                     upd = reg_q[g] | (onehot & rw);
                     clr = onehot & wc;
                  end
               end
               io_space_pkg::clear_register_bit_op: begin
                  if (in_bit_range) begin
                     upd = reg_q[g] & ~(onehot & rw);
                  end
               end
               default: upd = reg_q[g];
            endcase
         end
         // Set wins over clear on flags
         next_byte[g] = (upd & ~wc) | (((reg_q[g] & ~clr) | hw_set[g]) & wc);
      end
   end

   always_comb begin
      for (int i = 0; i < `IO_NREGS; i++) begin
         reg_d[i] = next_byte[i];
      end
   end

   // Answer to the core
   always_comb begin
      ack_d = acc_valid_i;
      rdata_d = rdata_q;
      skip_d = 1'b0;
      err_d = 1'b0;
      if (acc_valid_i) begin
         rdata_d = rd_val;
         if (bad_write) begin
            err_d = 1'b1;
         end
         if (bad_bitop) begin
            err_d = 1'b1;
         end
         if (in_bit_range) begin
            case (acc_kind_i)
               io_space_pkg::skip_if_register_bit_set: skip_d = bit_seen;
               io_space_pkg::skip_if_register_bit_clear: skip_d = !bit_seen;
               default: skip_d = 1'b0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_q <= '0;
         ack_q <= 1'b0;
         rdata_q <= `IO_RST_VAL;
         skip_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         reg_q <= reg_d;
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         skip_q <= skip_d;
         err_q <= err_d;
      end
   end

   assign acc_ack_o = ack_q;
   assign acc_rdata_o = rdata_q;
   assign acc_skip_o = skip_q;
   assign acc_err_o = err_q;
   assign port_a_out_o = reg_q[`PORT_A_OUTPUT];
   assign port_a_dir_o = reg_q[`PORT_A_DIRECTION];
   assign port_b_out_o = reg_q[`PORT_B_OUTPUT][3:0];
   assign reg_image_o = reg_q;
endmodule

/* File: io_space_checker_assertions.sv */
module io_space_checker (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic acc_valid_i,
   input wire io_space_pkg::access_kind_e acc_kind_i,
   input wire logic acc_data_space_i,
   input wire logic [8:0] acc_addr_i,
   input wire logic [2:0] acc_bit_i,
   input wire logic [7:0] acc_wdata_i,
   input wire logic acc_ack_o,
   input wire logic acc_skip_o,
   input wire logic acc_err_o,
   input wire logic [7:0] timer1_event_i,
   input wire logic [255:0] reg_image_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   logic [7:0] cur;
   logic io;
   function automatic logic [7:0] at(logic [255:0] im, logic [4:0] a);
      return im[{a, 3'h0} +: 8];
   endfunction
   assign cur = at(reg_image_o, acc_addr_i[4:0]);
   assign io = !acc_data_space_i && acc_addr_i <= 9'h01F;
   sequence s_scr;
      acc_valid_i && io && acc_addr_i >= 9'h013 && acc_addr_i <= 9'h015;
   endsequence
   sequence s_flg;
      acc_valid_i && io && acc_addr_i == 9'h00E && timer1_event_i == 8'h00;
   endsequence
   property p_ack;
      acc_valid_i |=> acc_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("no ack after request");
   property p_set;
      s_scr ##0 acc_kind_i == io_space_pkg::set_register_bit_op |=>
         at(reg_image_o, $past(acc_addr_i[4:0])) == ($past(cur) | (8'h01 << $past(acc_bit_i)));
   endproperty
   a_set: assert property (p_set) else $error("bit set wrong");
   property p_clr;
      s_scr ##0 acc_kind_i == io_space_pkg::clear_register_bit_op |=>
         at(reg_image_o, $past(acc_addr_i[4:0])) == ($past(cur) & ~(8'h01 << $past(acc_bit_i)));
   endproperty
   a_clr: assert property (p_clr) else $error("bit clear wrong");
   property p_skip;
      s_scr ##0 (acc_kind_i == io_space_pkg::skip_if_register_bit_set ||
         acc_kind_i == io_space_pkg::skip_if_register_bit_clear) |=>
         acc_skip_o == ($past(cur[acc_bit_i]) == $past(acc_kind_i[0] == 1'b0));
   endproperty
   a_skip: assert property (p_skip) else $error("skip decision wrong");
   property p_w1c;
      s_flg ##0 acc_kind_i == io_space_pkg::write_byte_op |=>
         at(reg_image_o, 5'h0E) == ($past(cur) & ~$past(acc_wdata_i));
   endproperty
   a_w1c: assert property (p_w1c) else $error("flag write wrong");
   property p_fset;
      s_flg ##0 acc_kind_i == io_space_pkg::set_register_bit_op |=>
         at(reg_image_o, 5'h0E) == ($past(cur) & ~(8'h01 << $past(acc_bit_i)));
   endproperty
   a_fset: assert property (p_fset) else $error("flag bit set wrong");
   property p_fclr;
      s_flg ##0 acc_kind_i == io_space_pkg::clear_register_bit_op |=>
         at(reg_image_o, 5'h0E) == $past(cur);
   endproperty
   a_fclr: assert property (p_fclr) else $error("flag bit clear wrong");
   property p_hi;
      acc_valid_i && acc_kind_i inside {io_space_pkg::set_register_bit_op,
         io_space_pkg::clear_register_bit_op} && !io |=> acc_err_o;
   endproperty
   a_hi: assert property (p_hi) else $error("bit op out of range taken");
   property p_rsv;
      acc_valid_i && io && acc_kind_i == io_space_pkg::write_byte_op &&
         acc_addr_i <= 9'h003 |=> acc_err_o;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved write taken");
   property p_dwr;
      acc_valid_i && acc_data_space_i && acc_kind_i == io_space_pkg::write_byte_op &&
         acc_addr_i >= 9'h033 && acc_addr_i <= 9'h035 |=>
         at(reg_image_o, $past(acc_addr_i[4:0])) == $past(acc_wdata_i);
   endproperty
   a_dwr: assert property (p_dwr) else $error("data space write lost");
   property p_dbit;
      acc_valid_i && acc_data_space_i && acc_addr_i >= 9'h033 && acc_addr_i <= 9'h035 &&
         acc_kind_i inside {io_space_pkg::set_register_bit_op,
         io_space_pkg::clear_register_bit_op} |=>
         at(reg_image_o, $past(acc_addr_i[4:0])) == $past(cur);
   endproperty
   a_dbit: assert property (p_dbit) else $error("data space bit op changed register");
   property p_evt;
      (timer1_event_i & 8'h27) != 8'h00 |=> (at(reg_image_o, 5'h0E) &
         $past(timer1_event_i & 8'h27)) == $past(timer1_event_i & 8'h27);
   endproperty
   a_evt: assert property (p_evt) else $error("flag event lost");
endmodule
bind io_register_space_bit_access io_space_checker u_chk (.clk_sys_i, .rst_b_i, .acc_valid_i,
   .acc_kind_i, .acc_data_space_i, .acc_addr_i, .acc_bit_i, .acc_wdata_i, .acc_ack_o,
   .acc_skip_o, .acc_err_o, .timer1_event_i, .reg_image_o);

/* File: core_model.sv */
module core_model (
   input wire logic clk_sys_i,
   output logic v_o,
   output io_space_pkg::access_kind_e k_o,
   output logic ds_o,
   output logic [8:0] a_o,
   output logic [2:0] b_o,
   output logic [7:0] w_o,
   input wire logic ack_i
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      v_o = 1'b0;
      k_o = io_space_pkg::read_byte_op;
      ds_o = 1'b0;
      a_o = 9'h000;
      b_o = 3'h0;
      w_o = 8'h00;
   end
   // Caller keeps reserved bits zero reserved writes only when asked
   task automatic access(input io_space_pkg::access_kind_e k, input logic ds,
      input logic [8:0] a, input logic [2:0] b, input logic [7:0] w, output logic ok);
      @(negedge clk_sys_i);
      v_o = 1'b1;
      k_o = k;
      ds_o = ds;
      a_o = a;
      b_o = b;
      w_o = w;
      @(negedge clk_sys_i);
      v_o = 1'b0;
      a_o = ~a;
      b_o = ~b;
      w_o = ~w;
      ok = ack_i;
   endtask
endmodule

/* File: io_register_space_bit_access_tb.sv */
module io_register_space_bit_access_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam io_space_pkg::access_kind_e k_rd = io_space_pkg::read_byte_op;
   localparam io_space_pkg::access_kind_e k_wr = io_space_pkg::write_byte_op;
   localparam io_space_pkg::access_kind_e k_st = io_space_pkg::set_register_bit_op;
   localparam io_space_pkg::access_kind_e k_cl = io_space_pkg::clear_register_bit_op;
   localparam io_space_pkg::access_kind_e k_ss = io_space_pkg::skip_if_register_bit_set;
   localparam io_space_pkg::access_kind_e k_sc = io_space_pkg::skip_if_register_bit_clear;
   logic clk_sys_i, rst_b_i, v, ds, ack, sk, er, c0, ok, ad, l0;
   io_space_pkg::access_kind_e k;
   logic [8:0] a;
   logic [2:0] b;
   logic [7:0] w, rd, t1, t2, pa, pa_out, pa_dir;
   logic [3:0] pb, pb_out;
   logic [15:0] adc;
   logic [255:0] image;
   int failures, checks_done;
   io_register_space_bit_access DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
      .acc_valid_i(v), .acc_kind_i(k), .acc_data_space_i(ds), .acc_addr_i(a), .acc_bit_i(b),
      .acc_wdata_i(w), .acc_ack_o(ack), .acc_rdata_o(rd), .acc_skip_o(sk), .acc_err_o(er),
      .timer1_event_i(t1), .timer2_event_i(t2), .adc_done_i(ad), .adc_result_i(adc),
      .cmp0_event_i(c0), .cmp1_event_i(c0), .cmp0_level_i(l0), .cmp1_level_i(1'b0),
      .port_a_pin_i(pa), .port_b_pin_i(pb), .port_a_out_o(pa_out), .port_a_dir_o(pa_dir),
      .port_b_out_o(pb_out), .reg_image_o(image));
   core_model u_core (.clk_sys_i(clk_sys_i), .v_o(v), .k_o(k), .ds_o(ds), .a_o(a), .b_o(b),
      .w_o(w), .ack_i(ack));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic acc(io_space_pkg::access_kind_e kk, logic d, logic [8:0] aa, logic [2:0] bb,
      logic [7:0] ww);
      u_core.access(kk, d, aa, bb, ww, ok);
      chk(8'(ok), 8'h01);
   endtask
   function automatic logic [7:0] img(input int n);
      return image[8*n +: 8];
   endfunction
   task automatic final_report;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      rst_b_i = 1'b0;
      t1 = 8'h00;
      t2 = 8'h00;
      ad = 1'b0;
      l0 = 1'b1;
      c0 = 1'b0;
      pa = 8'hC3;
      pb = 4'h5;
      adc = 16'h1234;
      failures = 0;
      checks_done = 0;
      repeat (4) @(negedge clk_sys_i);
      rst_b_i = 1'b1;
      acc(k_wr, 0, 9'h013, 0, 8'hA5);
      chk(8'(er), 8'h00);
      acc(k_rd, 1, 9'h033, 0, 0);
      chk(rd, 8'hA5);
      acc(k_wr, 1, 9'h035, 0, 8'h3C);
      chk(img(8'h15), 8'h3C);
      $display("test bytes done");
      for (int i = 0; i < 8; i++) begin
         acc(k_st, 0, 9'h014, i[2:0], 0);
         chk(img(8'h14), 8'((2 ** (i + 1)) - 1));
      end
      acc(k_cl, 0, 9'h014, 3'd3, 0);
      chk(img(8'h14), 8'hF7);
      acc(k_ss, 0, 9'h014, 3'd3, 0);
      chk(8'(sk), 8'h00);
      acc(k_sc, 0, 9'h014, 3'd3, 0);
      chk(8'(sk), 8'h01);
      acc(k_ss, 0, 9'h019, 3'd7, 0);
      chk(8'(sk), 8'h01);
      acc(k_sc, 0, 9'h016, 3'd1, 0);
      chk(8'(sk), 8'h01);
      acc(k_ss, 0, 9'h00A, 3'd5, 0);
      chk(8'(sk), 8'h01);
      $display("test bits done");
      @(negedge clk_sys_i);
      t1 = 8'h27;
      t2 = 8'h01;
      ad = 1'b1;
      c0 = 1'b1;
      @(negedge clk_sys_i);
      t1 = 8'h00;
      t2 = 8'h00;
      ad = 1'b0;
      c0 = 1'b0;
      acc(k_rd, 0, 9'h00E, 0, 0);
      chk(rd, 8'h27);
      acc(k_st, 0, 9'h00E, 3'd0, 0);
      chk(img(8'h0E), 8'h26);
      acc(k_cl, 0, 9'h00E, 3'd1, 0);
      chk(img(8'h0E), 8'h26);
      acc(k_wr, 0, 9'h00E, 0, 8'h00);
      chk(img(8'h0E), 8'h26);
      acc(k_wr, 0, 9'h00E, 0, 8'h24);
      chk(img(8'h0E), 8'h02);
      acc(k_st, 0, 9'h00A, 3'd0, 0);
      chk(img(8'h0A), 8'h11);
      chk(img(8'h0C), 8'h10);
      chk(img(8'h10), 8'h01);
      acc(k_wr, 0, 9'h010, 0, 8'h01);
      chk(img(8'h10), 8'h00);
      chk(img(8'h05), 8'h10);
      acc(k_st, 0, 9'h005, 3'd4, 0);
      chk(img(8'h05), 8'h00);
      $display("test flags done");
      acc(k_st, 0, 9'h020, 3'd0, 0);
      chk(8'(er), 8'h01);
      acc(k_cl, 1, 9'h033, 3'd0, 0);
      chk(8'(er), 8'h01);
      chk(img(8'h13), 8'hA5);
      acc(k_wr, 0, 9'h001, 0, 8'h55);
      chk(8'(er), 8'h01);
      chk(img(8'h01), 8'h00);
      acc(k_wr, 1, 9'h060, 0, 8'h55);
      chk(8'(er), 8'h01);
      $display("test refused done");
      acc(k_wr, 1, 9'h03B, 0, 8'h5A);
      chk(pa_out, 8'h5A);
      acc(k_st, 0, 9'h018, 3'd2, 0);
      chk({4'h0, pb_out}, 8'h04);
      acc(k_rd, 0, 9'h018, 0, 0);
      chk(rd, 8'h04);
      acc(k_st, 0, 9'h01A, 3'd7, 0);
      chk(pa_dir, 8'h80);
      acc(k_rd, 1, 9'h027, 0, 0);
      chk(rd, 8'h12);
      $display("test ports done");
      final_report();
   end
endmodule
